// *** rtl/chi_sequencer.v ***
// Card host command sequencer with APB registers and a receive FIFO.
`timescale 1ns/1ns
`default_nettype none
`include "chi_regs.vh"
// Contract
// - Relative-address commands carry the card's address in bits 31:16.
// - Start bit begins the command frame; line driven through the end bit.
// - No-response command ends with busy cleared and command-sent flag.
// - A missing expected response raises the response timeout flag.
// - No-data command ends at response with busy cleared, response flag.
// - Card data-busy is a status bit; its end raises busy-end flag.
// - Command and data pins float when undriven; pull-ups read high.
// - Open-ended multi-block read suspends after every block.
// - A full FIFO between blocks suspends the sequence until continued.
// - Block suspension flags transfer end; FIFO suspension flags FIFO full.
// - Read end clears busy and flags transfer end or block-count end.
// - Abort after CRC error or data timeout clears FIFO, ends sequence.
// - Block counter decrements per block; sequence ends at zero.
module chi_sequencer (
	input wire core_clk, // System clock, 20 MHz.
	input wire resetn, // Synchronous reset, active low.
	input wire psel, // APB select.
	input wire penable, // APB enable.
	input wire pwrite, // APB write.
	input wire [7:0] paddr, // APB byte address.
	input wire [31:0] pwdata, // APB write data.
	output reg [31:0] prdata, // APB read data.
	output reg pready, // APB ready.
	output reg pslverr, // APB error for unmapped address.
	input wire link_clk_in, // Card transfer clock, sampled.
	input wire cmd_line_pin_in, // Command line level.
	output reg cmd_line_pin_out, // Command line drive value.
	output reg cmd_line_pin_oe_n, // Command line enable, low drives.
	input wire data_line_pin_in, // Data line level.
	output reg data_line_pin_out, // Data line drive value.
	output reg data_line_pin_oe_n // Data line enable, low drives.
);
	localparam S_IDLE = 3'd0;
	localparam S_CTX = 3'd1;
	localparam S_RWAIT = 3'd2;
	localparam S_RRX = 3'd3;
	localparam S_DWAIT = 3'd4;
	localparam S_DRX = 3'd5;
	localparam S_SUSP = 3'd6;
	localparam S_ERR = 3'd7;

	function [6:0] crc7_step;
		input [6:0] c;
		input b;
		begin
			crc7_step = {c[5:0], 1'b0} ^ ((b ^ c[6]) ? 7'h09 : 7'h00);
		end
	endfunction

	function [15:0] crc16_step;
		input [15:0] c;
		input b;
		begin
			crc16_step = {c[14:0], 1'b0} ^ ((b ^ c[15]) ? 16'h1021 : 16'h0000);
		end
	endfunction

	wire [2:0] sync_w;
	reg lclk_prev_q;
	reg [2:0] state_q;
	reg busy_q;
	reg [31:0] cfg_q;
	reg [31:0] arg_q;
	reg [15:0] rca_q;
	reg [15:0] blk_q;
	reg [31:0] resp_q;
	reg [`CHI_NFLAGS-1:0] flags_q;
	reg [`CHI_NFLAGS-1:0] flag_pulse_q;
	reg [7:0] cnt_q;
	reg [39:0] tx_q;
	reg [47:0] rx_q;
	reg [6:0] crc7_q;
	reg [15:0] crc16_q;
	reg [7:0] byte_q;
	reg [15:0] tout_q;
	reg watch_q;
	reg card_busy_q;
	reg [7:0] fifo_mem [0:31];
	reg [5:0] wp_q;
	reg [5:0] rp_q;

	chi_sync #(.W(3)) u_sync (
		.core_clk(core_clk),
		.resetn(resetn),
		.d_async({link_clk_in, cmd_line_pin_in, data_line_pin_in}),
		.d_sync(sync_w)
	);

	wire l_rise = sync_w[2] & ~lclk_prev_q;
	wire l_fall = ~sync_w[2] & lclk_prev_q;
	wire cmd_i = sync_w[1];
	wire dat_i = sync_w[0];
	wire wr_en = psel & penable & pwrite & pready;
	wire rd_en = psel & penable & ~pwrite & pready;
	wire [5:0] fifo_cnt = wp_q - rp_q;
	wire fifo_empty = (fifo_cnt == 6'h00);
	wire no_room = (fifo_cnt > (`CHI_FIFO_DEPTH - `CHI_BLK_BYTES));
	wire [5:0] idx = cfg_q[5:0];
	wire [1:0] rtype = cfg_q[7:6];
	wire [1:0] dmode = cfg_q[9:8];
	wire use_rca = cfg_q[10];
	wire [47:0] rx_next = {rx_q[46:0], cmd_i};
	wire [7:0] byte_next = {byte_q[6:0], dat_i};
	wire start_wr = wr_en && paddr == `CHI_OFF_START && pwdata[`CHI_START_BIT];
	wire abort_wr = wr_en && paddr == `CHI_OFF_OPCTL && pwdata[`CHI_ABORT_BIT];
	wire cont_wr = wr_en && paddr == `CHI_OFF_OPCTL && pwdata[`CHI_RDCONT_BIT];
	wire clr_wr = wr_en && paddr == `CHI_OFF_FIFOCLR;
	wire push = state_q == S_DRX && l_rise && cnt_q < `CHI_BLK_DATA_BITS &&
		cnt_q[2:0] == 3'h7;
	wire pop = rd_en && paddr == `CHI_OFF_DATA && !fifo_empty;
	wire [`CHI_NFLAGS-1:0] flag_clr = (wr_en && paddr == `CHI_OFF_FLAGS) ?
		pwdata[`CHI_NFLAGS-1:0] : {`CHI_NFLAGS{1'b0}};
	wire addr_ok = paddr[1:0] == 2'h0 && paddr <= `CHI_OFF_FIFOCLR;

	// APB slave: zero-wait, ready in the first access cycle.
	always @(posedge core_clk) begin
		if (!resetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & ~addr_ok;
			if (psel && !penable && !pwrite) begin
				case (paddr)
				`CHI_OFF_STATUS: prdata <= {29'h0000_0000,
					state_q == S_SUSP, card_busy_q, busy_q};
				`CHI_OFF_FLAGS: prdata <= {23'h00_0000, flags_q};
				`CHI_OFF_CFG: prdata <= cfg_q;
				`CHI_OFF_ARG: prdata <= arg_q;
				`CHI_OFF_RCA: prdata <= {rca_q, 16'h0000};
				`CHI_OFF_BLKCNT: prdata <= {16'h0000, blk_q};
				`CHI_OFF_RESP: prdata <= resp_q;
				`CHI_OFF_DATA: prdata <= {24'h00_0000, fifo_mem[rp_q[4:0]]};
				default: prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Flags are sticky; a new event beats a clear in the same cycle.
	always @(posedge core_clk) begin
		if (!resetn) begin
			flags_q <= {`CHI_NFLAGS{1'b0}};
		end else begin
			flags_q <= (flags_q & ~flag_clr) | flag_pulse_q;
		end
	end

	// Receive FIFO storage.
	always @(posedge core_clk) begin
		if (push) begin
			fifo_mem[wp_q[4:0]] <= byte_next;
		end
	end

	always @(posedge core_clk) begin
		if (!resetn) begin
			wp_q <= 6'h00;
			rp_q <= 6'h00;
		end else if (clr_wr || abort_wr) begin
			wp_q <= 6'h00;
			rp_q <= 6'h00;
		end else begin
			if (push) begin
				wp_q <= wp_q + 6'h01;
			end
			if (pop) begin
				rp_q <= rp_q + 6'h01;
			end
		end
	end

	// Setup registers. The block counter is also stepped by the sequencer.
	always @(posedge core_clk) begin
		if (!resetn) begin
			cfg_q <= `CHI_CFG_RESET;
			arg_q <= 32'h0000_0000;
			rca_q <= 16'h0000;
		end else if (wr_en) begin
			if (paddr == `CHI_OFF_CFG) begin
				cfg_q <= pwdata;
			end
			if (paddr == `CHI_OFF_ARG) begin
				arg_q <= pwdata;
			end
			if (paddr == `CHI_OFF_RCA) begin
				rca_q <= pwdata[31:16];
			end
		end
	end

	// Card data-busy watch after a busy-type response.
	always @(posedge core_clk) begin
		if (!resetn || abort_wr || start_wr) begin
			watch_q <= 1'b0;
			card_busy_q <= 1'b0;
		end else begin
			if (state_q == S_RRX && l_rise && cnt_q == `CHI_FRAME_BITS &&
				rtype == `CHI_RESP_BUSY) begin
				watch_q <= 1'b1;
			end
			if (watch_q && !dat_i) begin
				card_busy_q <= 1'b1;
			end else if (watch_q && card_busy_q && dat_i) begin
				card_busy_q <= 1'b0;
				watch_q <= 1'b0;
			end
		end
	end

	// Command and data sequencer.
	always @(posedge core_clk) begin
		if (!resetn) begin
			lclk_prev_q <= 1'b1;
			state_q <= S_IDLE;
			busy_q <= 1'b0;
			blk_q <= 16'h0000;
			resp_q <= 32'h0000_0000;
			flag_pulse_q <= {`CHI_NFLAGS{1'b0}};
			cnt_q <= 8'h00;
			tx_q <= 40'h00_0000_0000;
			rx_q <= 48'h0000_0000_0000;
			crc7_q <= 7'h00;
			crc16_q <= 16'h0000;
			byte_q <= 8'h00;
			tout_q <= 16'h0000;
			cmd_line_pin_out <= 1'b1;
			cmd_line_pin_oe_n <= 1'b1;
			data_line_pin_out <= 1'b1;
			data_line_pin_oe_n <= 1'b1;
		end else begin
			lclk_prev_q <= sync_w[2];
			flag_pulse_q <= {`CHI_NFLAGS{1'b0}};
			flag_pulse_q[`CHI_FL_BUSY_END] <= watch_q & card_busy_q & dat_i;
			if (wr_en && paddr == `CHI_OFF_BLKCNT) begin
				blk_q <= pwdata[15:0];
			end
			if (abort_wr) begin
				// Abort wins over everything and releases the line at once.
				state_q <= S_IDLE;
				busy_q <= 1'b0;
				cmd_line_pin_oe_n <= 1'b1;
				cmd_line_pin_out <= 1'b1;
			end else begin
				case (state_q)
				S_IDLE: begin
					if (start_wr) begin
						busy_q <= 1'b1;
						state_q <= S_CTX;
						cnt_q <= 8'h00;
						crc7_q <= 7'h00;
						tx_q <= {2'b01, idx,
							use_rca ? {rca_q, arg_q[15:0]} : arg_q};
					end
				end
				S_CTX: begin
					// Bits change on falling edges so the card samples on rising.
					if (l_fall) begin
						cnt_q <= cnt_q + 8'h01;
						if (cnt_q < `CHI_CMD_BITS) begin
							cmd_line_pin_oe_n <= 1'b0;
							cmd_line_pin_out <= tx_q[39];
							tx_q <= {tx_q[38:0], 1'b0};
							crc7_q <= crc7_step(crc7_q, tx_q[39]);
						end else if (cnt_q < `CHI_FRAME_BITS) begin
							cmd_line_pin_out <= crc7_q[6];
							crc7_q <= {crc7_q[5:0], 1'b0};
						end else if (cnt_q == `CHI_FRAME_BITS) begin
							cmd_line_pin_out <= 1'b1;
						end else begin
							// End bit has stood a full period; release.
							cmd_line_pin_oe_n <= 1'b1;
							flag_pulse_q[`CHI_FL_CMD_SENT] <= 1'b1;
							tout_q <= 16'h0000;
							if (rtype == `CHI_RESP_NONE) begin
								busy_q <= 1'b0;
								state_q <= S_IDLE;
							end else begin
								state_q <= S_RWAIT;
							end
						end
					end
				end
				S_RWAIT: begin
					if (l_rise) begin
						if (!cmd_i) begin
							state_q <= S_RRX;
							cnt_q <= 8'h01;
							rx_q <= rx_next;
							crc7_q <= crc7_step(7'h00, cmd_i);
						end else if (tout_q[7:0] == `CHI_RESP_TOUT) begin
							flag_pulse_q[`CHI_FL_RESP_TOUT] <= 1'b1;
							state_q <= S_ERR;
						end else begin
							tout_q <= tout_q + 16'h0001;
						end
					end
				end
				S_RRX: begin
					if (l_rise) begin
						rx_q <= rx_next;
						cnt_q <= cnt_q + 8'h01;
						if (cnt_q < `CHI_CMD_BITS) begin
							crc7_q <= crc7_step(crc7_q, cmd_i);
						end
						if (cnt_q == `CHI_FRAME_BITS) begin
							resp_q <= rx_next[39:8];
							tout_q <= 16'h0000;
							if (rx_next[7:1] != crc7_q) begin
								flag_pulse_q[`CHI_FL_CRC_FAIL] <= 1'b1;
								state_q <= S_ERR;
							end else begin
								flag_pulse_q[`CHI_FL_RESP_RCVD] <= 1'b1;
								if (dmode == `CHI_DM_NONE) begin
									busy_q <= 1'b0;
									state_q <= S_IDLE;
								end else begin
									state_q <= S_DWAIT;
								end
							end
						end
					end
				end
				S_DWAIT: begin
					if (l_rise) begin
						if (!dat_i) begin
							state_q <= S_DRX;
							cnt_q <= 8'h00;
							crc16_q <= 16'h0000;
						end else if (tout_q == `CHI_DATA_TOUT) begin
							flag_pulse_q[`CHI_FL_DATA_TOUT] <= 1'b1;
							state_q <= S_ERR;
						end else begin
							tout_q <= tout_q + 16'h0001;
						end
					end
				end
				S_DRX: begin
					if (l_rise) begin
						cnt_q <= cnt_q + 8'h01;
						byte_q <= byte_next;
						if (cnt_q < `CHI_BLK_CRC_END) begin
							// Data plus its CRC leaves a zero remainder.
							crc16_q <= crc16_step(crc16_q, dat_i);
						end else begin
							tout_q <= 16'h0000;
							if (crc16_q != 16'h0000) begin
								flag_pulse_q[`CHI_FL_CRC_FAIL] <= 1'b1;
								state_q <= S_ERR;
							end else if (dmode == `CHI_DM_SINGLE) begin
								busy_q <= 1'b0;
								flag_pulse_q[`CHI_FL_XFER_END] <= 1'b1;
								state_q <= S_IDLE;
							end else if (dmode == `CHI_DM_PREDEF &&
								blk_q == 16'h0001) begin
								blk_q <= 16'h0000;
								busy_q <= 1'b0;
								flag_pulse_q[`CHI_FL_BLK_END] <= 1'b1;
								state_q <= S_IDLE;
							end else begin
								if (dmode == `CHI_DM_PREDEF) begin
									blk_q <= blk_q - 16'h0001;
								end
								if (dmode == `CHI_DM_OPEN) begin
									flag_pulse_q[`CHI_FL_XFER_END] <= 1'b1;
									state_q <= S_SUSP;
								end else if (no_room) begin
									state_q <= S_SUSP;
								end else begin
									state_q <= S_DWAIT;
								end
								// A FIFO that cannot take a whole block stops the stream.
								flag_pulse_q[`CHI_FL_FIFO_FULL] <= no_room;
							end
						end
					end
				end
				S_SUSP: begin
					if (cont_wr) begin
						tout_q <= 16'h0000;
						state_q <= S_DWAIT;
					end
				end
				S_ERR: begin
					// Stays busy; only an abort leaves here.
					busy_q <= 1'b1;
				end
				default: begin
					state_q <= S_IDLE;
				end
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// *** rtl/chi_regs.vh ***
// Register offsets, field positions, reset values and counts for the sequencer.
`ifndef CHI_REGS_VH
`define CHI_REGS_VH
`define CHI_OFF_START 8'h00
`define CHI_OFF_OPCTL 8'h04
`define CHI_OFF_STATUS 8'h08
`define CHI_OFF_FLAGS 8'h0C
`define CHI_OFF_CFG 8'h10
`define CHI_OFF_ARG 8'h14
`define CHI_OFF_RCA 8'h18
`define CHI_OFF_BLKCNT 8'h1C
`define CHI_OFF_RESP 8'h20
`define CHI_OFF_DATA 8'h24
`define CHI_OFF_FIFOCLR 8'h28
`define CHI_START_BIT 0
`define CHI_ABORT_BIT 0
`define CHI_RDCONT_BIT 1
`define CHI_ST_BUSY 0
`define CHI_ST_CARD_BUSY 1
`define CHI_ST_SUSP 2
`define CHI_FL_CMD_SENT 0
`define CHI_FL_RESP_RCVD 1
`define CHI_FL_RESP_TOUT 2
`define CHI_FL_CRC_FAIL 3
`define CHI_FL_DATA_TOUT 4
`define CHI_FL_BUSY_END 5
`define CHI_FL_XFER_END 6
`define CHI_FL_FIFO_FULL 7
`define CHI_FL_BLK_END 8
`define CHI_NFLAGS 9
`define CHI_CFG_RESET 32'h0000_0000
`define CHI_RESP_NONE 2'h0
`define CHI_RESP_SHORT 2'h1
`define CHI_RESP_BUSY 2'h2
`define CHI_DM_NONE 2'h0
`define CHI_DM_SINGLE 2'h1
`define CHI_DM_OPEN 2'h2
`define CHI_DM_PREDEF 2'h3
`define CHI_CMD_BITS 8'h28
`define CHI_FRAME_BITS 8'h2F
`define CHI_FRAME_DONE 8'h30
`define CHI_RESP_TOUT 8'h40
`define CHI_DATA_TOUT 16'h0400
`define CHI_BLK_DATA_BITS 8'h80
`define CHI_BLK_CRC_END 8'h90
`define CHI_BLK_BYTES 6'h10
`define CHI_FIFO_DEPTH 6'h20
`endif

// *** rtl/chi_sync.v ***
// Two-flop synchroniser for a group of asynchronous inputs.
`timescale 1ns/1ns
`default_nettype none
module chi_sync #(
	parameter W = 3
) (
	input wire core_clk, // Sampling clock.
	input wire resetn, // Synchronous reset, active low.
	input wire [W-1:0] d_async, // Inputs from outside the clock domain.
	output wire [W-1:0] d_sync // Synchronised copies.
);
	reg [W-1:0] s1_q;
	reg [W-1:0] s2_q;
	genvar i;
	generate
		for (i = 0; i < W; i = i + 1) begin : g_bit
			// Idle lines are pulled up, so reset to high.
			always @(posedge core_clk) begin
				if (!resetn) begin
					s1_q[i] <= 1'b1;
					s2_q[i] <= 1'b1;
				end else begin
					s1_q[i] <= d_async[i];
					s2_q[i] <= s1_q[i];
				end
			end
		end
	endgenerate
	assign d_sync = s2_q;
endmodule
`default_nettype wire

// *** tb/chi_sequencer_properties.sv ***
// Port-level assertions for the card host command sequencer.
`timescale 1ns/1ns
`default_nettype none
`include "chi_regs.vh"
module chi_sequencer_properties (
	input wire core_clk, // Clock.
	input wire resetn, // Reset, active low.
	input wire psel, // Select.
	input wire penable, // Enable.
	input wire pwrite, // Direction.
	input wire [7:0] paddr, // Address.
	input wire [31:0] prdata, // Read data.
	input wire pready, // Ready.
	input wire pslverr, // Error.
	input wire cmd_line_pin_oe_n, // Command enable.
	input wire data_line_pin_out, // Data value.
	input wire data_line_pin_oe_n // Data enable.
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);
	wire setup = psel && !penable;
	wire bad = paddr[1:0] != 2'h0 || paddr > `CHI_OFF_FIFOCLR;
	ready_after_setup_a: assert property (setup |=> pready)
		else $error("no ready after setup");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready held too long");
	err_with_ready_a: assert property (pslverr |-> pready)
		else $error("error without ready");
	bad_addr_err_a: assert property (setup && bad && !pwrite
		|=> pslverr && prdata == 32'h0000_0000)
		else $error("unmapped read not refused");
	good_addr_ok_a: assert property (setup && !bad |=> !pslverr)
		else $error("mapped access refused");
	data_float_a: assert property (data_line_pin_oe_n && data_line_pin_out)
		else $error("data line driven");
	frame_held_a: assert property ($fell(cmd_line_pin_oe_n)
		|-> !cmd_line_pin_oe_n [*8])
		else $error("command frame cut short");
	frame_length_a: assert property ($fell(cmd_line_pin_oe_n)
		|-> ##[376:392] $rose(cmd_line_pin_oe_n))
		else $error("command frame length wrong");
	reset_quiet_a: assert property (disable iff (1'b0) !resetn
		|=> !pready && !pslverr && cmd_line_pin_oe_n)
		else $error("outputs active in reset");
	cover property ($fell(cmd_line_pin_oe_n));
	cover property (pslverr);
	cover property (setup && pwrite && paddr == `CHI_OFF_OPCTL);
endmodule
bind chi_sequencer chi_sequencer_properties u_prop (.core_clk(core_clk),
	.resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.cmd_line_pin_oe_n(cmd_line_pin_oe_n),
	.data_line_pin_out(data_line_pin_out),
	.data_line_pin_oe_n(data_line_pin_oe_n));
`default_nettype wire

// *** tb/chi_card_model.sv ***
// Behavioural card: takes a command, answers, then busy or data blocks.
`timescale 1ns/1ns
`default_nettype none
module chi_card_model (
	input wire logic run, // Link clock runs while high.
	input wire logic [1:0] mode, // 0 silent, 1 reply, 2 busy, 3 bad CRC.
	input wire logic [3:0] nblk, // Blocks sent after the reply.
	input wire logic cmd_w, // Resolved command wire.
	output logic lclk, // Link clock.
	output logic cmd_oe_n, // Card drives command when low.
	output logic cmd_o, // Card command value.
	output logic dat_oe_n, // Card drives data when low.
	output logic dat_o, // Card data value.
	output logic [47:0] frm, // Last command frame seen.
	output logic crc_ok // Its CRC and framing were good.
);
	// Address this card was given; the bench programs the same value.
	localparam logic [15:0] OWN_RCA = 16'hA5C3;
	logic [47:0] rsp;
	logic sel;
	logic [145:0] dat;
	int i, b;
	function automatic logic [6:0] crc7(input logic [39:0] d);
		crc7 = 7'h00;
		for (int j = 39; j >= 0; j--)
			crc7 = {crc7[5:0], 1'b0} ^ ((crc7[6] ^ d[j]) ? 7'h09 : 7'h00);
	endfunction
	function automatic logic [15:0] crc16(input logic [127:0] d);
		crc16 = 16'h0000;
		for (int j = 127; j >= 0; j--)
			crc16 = {crc16[14:0], 1'b0} ^
				((crc16[15] ^ d[j]) ? 16'h1021 : 16'h0000);
	endfunction
	initial begin
		{lclk, cmd_oe_n, cmd_o, dat_oe_n, dat_o, crc_ok} = 6'h3E;
		frm = 48'h0;
		sel = 1'b0;
	end
	// The clock stands still between sequences, as a real host's would.
	always #200 if (run) lclk = ~lclk;
	always begin
		do
			@(posedge lclk);
		while (cmd_w !== 1'b0);
		for (i = 0; i < 47; i++) begin
			@(posedge lclk);
			frm = {frm[46:0], cmd_w};
		end
		// The start bit was seen but not stored; it is the leading zero.
		crc_ok = frm[46] && frm[0] &&
			crc7({1'b0, frm[46:8]}) == frm[7:1];
		// Only the card whose address a select carries stays in transfer.
		if (frm[45:40] == 6'h07)
			sel = frm[39:24] == OWN_RCA;
		if (mode != 2'h0) begin
			rsp = {2'h0, frm[45:40], ~frm[39:8], 8'h01};
			rsp[7:1] = crc7(rsp[47:8]) ^ {5'h00, mode == 2'h3, 1'b0};
			repeat (2) @(posedge lclk);
			for (i = 47; i >= 0; i--) begin
				@(negedge lclk);
				{cmd_oe_n, cmd_o} = {1'b0, rsp[i]};
			end
			@(negedge lclk);
			cmd_oe_n = 1'b1;
		end
		if (mode == 2'h2) begin
			{dat_oe_n, dat_o} = 2'h0;
			repeat (8) @(negedge lclk);
			{dat_oe_n, dat_o} = 2'h3;
		end
		for (b = 0; sel && b < nblk; b++) begin
			for (i = 0; i < 16; i++)
				dat = {dat[137:0], b[3:0], i[3:0]};
			dat = {1'b0, dat[127:0], crc16(dat[127:0]), 1'b1};
			repeat (8) @(posedge lclk);
			for (i = 145; i >= 0; i--) begin
				@(negedge lclk);
				{dat_oe_n, dat_o} = {1'b0, dat[i]};
			end
			@(negedge lclk);
			dat_oe_n = 1'b1;
		end
	end
endmodule
`default_nettype wire

// *** tb/chi_sequencer_tb.sv ***
// Self-checking bench for the card host command sequencer.
`timescale 1ns/1ns
`default_nettype none
`include "chi_regs.vh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
	$display("unexpected %s: expected %h seen %h", n, e, g); end end
module chi_sequencer_tb;
	logic core_clk, resetn, psel, penable, pwrite, run, err, crc_ok;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic pready, pslverr, lclk, c_oe_n, c_o, d_oe_n, d_o;
	logic cmd_out, cmd_oe_n, dat_out, dat_oe_n;
	logic [1:0] mode;
	logic [3:0] nblk;
	logic [47:0] frm;
	int fails, num_checks;
	// Pull-ups: a line nobody drives reads high.
	wire cmd_w = !cmd_oe_n ? cmd_out : !c_oe_n ? c_o : 1'b1;
	wire dat_w = !dat_oe_n ? dat_out : !d_oe_n ? d_o : 1'b1;
	chi_sequencer uut (.core_clk(core_clk), .resetn(resetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.link_clk_in(lclk), .cmd_line_pin_in(cmd_w),
		.cmd_line_pin_out(cmd_out), .cmd_line_pin_oe_n(cmd_oe_n),
		.data_line_pin_in(dat_w), .data_line_pin_out(dat_out),
		.data_line_pin_oe_n(dat_oe_n));
	chi_card_model card (.run(run), .mode(mode), .nblk(nblk), .cmd_w(cmd_w),
		.lclk(lclk), .cmd_oe_n(c_oe_n), .cmd_o(c_o), .dat_oe_n(d_oe_n),
		.dat_o(d_o), .frm(frm), .crc_ok(crc_ok));
	always #25 core_clk = ~core_clk;
	function automatic logic [8:0] f(input int a);
		return 9'h001 << a;
	endfunction
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge core_clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
		@(posedge core_clk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge core_clk);
			if (pready === 1'b1)
				break;
		end
		{r, err} = {prdata, pslverr};
		{psel, penable} <= 2'h0;
		if (n == 20) begin
			fails++;
			$display("unexpected pready: expected 1 seen %b", pready);
			final_report();
		end
	endtask
	task automatic wt(input logic [7:0] a, input int b, input logic v);
		for (int n = 0; n < 4000; n++) begin
			apb(1'b0, a, 0);
			if (r[b] === v)
				return;
		end
		fails++;
		$display("unexpected bit %0d at %h: expected %b seen %b", b, a, v, r[b]);
		final_report();
	endtask
	task automatic go(input logic [10:0] cfg, input logic [1:0] m,
		input logic [3:0] nb);
		{mode, nblk} <= {m, nb};
		apb(1'b1, `CHI_OFF_FLAGS, 32'h0000_01FF);
		apb(1'b1, `CHI_OFF_FIFOCLR, 0);
		apb(1'b1, `CHI_OFF_CFG, {21'h0, cfg});
		apb(1'b1, `CHI_OFF_ARG, 32'h1234_5678);
		apb(1'b1, `CHI_OFF_RCA, 32'hA5C3_0000);
		run <= 1'b1;
		apb(1'b1, `CHI_OFF_START, 1);
		apb(1'b0, `CHI_OFF_STATUS, 0);
		`CHK("busy", 1'b1, r[`CHI_ST_BUSY])
	endtask
	task automatic drain(input logic [3:0] b);
		for (int k = 0; k < 16; k++) begin
			apb(1'b0, `CHI_OFF_DATA, 0);
			`CHK("byte", {b, 4'(k)}, r[7:0])
		end
	endtask
	task automatic t_noresp();
		go({1'b0, `CHI_DM_NONE, `CHI_RESP_NONE, 6'h00}, 2'h0, 4'h0);
		wt(`CHI_OFF_STATUS, `CHI_ST_BUSY, 1'b0);
		apb(1'b0, `CHI_OFF_FLAGS, 0);
		`CHK("flags", f(`CHI_FL_CMD_SENT), r[8:0])
		`CHK("frame", 1'b1, crc_ok)
		apb(1'b0, 8'h2C, 0);
		`CHK("slverr", 1'b1, err)
		run <= 1'b0;
	endtask
	task automatic t_rca();
		go({1'b1, `CHI_DM_NONE, `CHI_RESP_SHORT, 6'h07}, 2'h1, 4'h0);
		wt(`CHI_OFF_STATUS, `CHI_ST_BUSY, 1'b0);
		`CHK("arg", 32'hA5C3_5678, frm[39:8])
		`CHK("index", 6'h07, frm[45:40])
		apb(1'b0, `CHI_OFF_FLAGS, 0);
		`CHK("flags", f(`CHI_FL_CMD_SENT) | f(`CHI_FL_RESP_RCVD), r[8:0])
		apb(1'b0, `CHI_OFF_RESP, 0);
		`CHK("resp", ~32'hA5C3_5678, r)
		run <= 1'b0;
	endtask
	task automatic t_busy();
		go({1'b0, `CHI_DM_NONE, `CHI_RESP_BUSY, 6'h26}, 2'h2, 4'h0);
		wt(`CHI_OFF_STATUS, `CHI_ST_CARD_BUSY, 1'b1);
		`CHK("busy", 1'b0, r[`CHI_ST_BUSY])
		wt(`CHI_OFF_STATUS, `CHI_ST_CARD_BUSY, 1'b0);
		apb(1'b0, `CHI_OFF_FLAGS, 0);
		`CHK("busy end", 1'b1, r[`CHI_FL_BUSY_END])
		run <= 1'b0;
	endtask
	task automatic t_err();
		for (int m = 0; m < 4; m += 3) begin
			go({1'b1, `CHI_DM_NONE, `CHI_RESP_SHORT, 6'h0D}, 2'(m), 4'h0);
			wt(`CHI_OFF_FLAGS, m ? `CHI_FL_CRC_FAIL : `CHI_FL_RESP_TOUT,
				1'b1);
			apb(1'b0, `CHI_OFF_STATUS, 0);
			`CHK("busy", 1'b1, r[`CHI_ST_BUSY])
			apb(1'b1, `CHI_OFF_OPCTL, 1);
			apb(1'b0, `CHI_OFF_STATUS, 0);
			`CHK("busy", 1'b0, r[`CHI_ST_BUSY])
			run <= 1'b0;
		end
		// The card answers but sends no block, so the data wait runs out.
		go({1'b0, `CHI_DM_SINGLE, `CHI_RESP_SHORT, 6'h11}, 2'h1, 4'h0);
		wt(`CHI_OFF_FLAGS, `CHI_FL_DATA_TOUT, 1'b1);
		apb(1'b1, `CHI_OFF_OPCTL, 1);
		apb(1'b0, `CHI_OFF_STATUS, 0);
		`CHK("busy", 1'b0, r[`CHI_ST_BUSY])
		run <= 1'b0;
	endtask
	task automatic t_single();
		go({1'b0, `CHI_DM_SINGLE, `CHI_RESP_SHORT, 6'h11}, 2'h1, 4'h1);
		wt(`CHI_OFF_STATUS, `CHI_ST_BUSY, 1'b0);
		apb(1'b0, `CHI_OFF_FLAGS, 0);
		`CHK("xfer end", 1'b1, r[`CHI_FL_XFER_END])
		drain(4'h0);
		run <= 1'b0;
	endtask
	task automatic t_open();
		go({1'b0, `CHI_DM_OPEN, `CHI_RESP_SHORT, 6'h12}, 2'h1, 4'h2);
		wt(`CHI_OFF_STATUS, `CHI_ST_SUSP, 1'b1);
		run <= 1'b0;
		`CHK("busy", 1'b1, r[`CHI_ST_BUSY])
		apb(1'b0, `CHI_OFF_FLAGS, 0);
		`CHK("flags", 9'h043, r[8:0])
		drain(4'h0);
		run <= 1'b1;
		apb(1'b1, `CHI_OFF_OPCTL, 2);
		wt(`CHI_OFF_STATUS, `CHI_ST_SUSP, 1'b1);
		drain(4'h1);
		apb(1'b1, `CHI_OFF_OPCTL, 1);
		apb(1'b0, `CHI_OFF_STATUS, 0);
		`CHK("busy", 1'b0, r[`CHI_ST_BUSY])
		run <= 1'b0;
	endtask
	task automatic t_predef();
		apb(1'b1, `CHI_OFF_BLKCNT, 3);
		go({1'b0, `CHI_DM_PREDEF, `CHI_RESP_SHORT, 6'h12}, 2'h1, 4'h3);
		wt(`CHI_OFF_STATUS, `CHI_ST_SUSP, 1'b1);
		run <= 1'b0;
		apb(1'b0, `CHI_OFF_FLAGS, 0);
		`CHK("fifo full", 1'b1, r[`CHI_FL_FIFO_FULL])
		apb(1'b0, `CHI_OFF_BLKCNT, 0);
		`CHK("blocks", 32'h1, r)
		drain(4'h0);
		drain(4'h1);
		run <= 1'b1;
		apb(1'b1, `CHI_OFF_OPCTL, 2);
		wt(`CHI_OFF_STATUS, `CHI_ST_BUSY, 1'b0);
		apb(1'b0, `CHI_OFF_FLAGS, 0);
		`CHK("blk end", 1'b1, r[`CHI_FL_BLK_END])
		apb(1'b0, `CHI_OFF_BLKCNT, 0);
		`CHK("blocks", 32'h0, r)
		drain(4'h2);
		run <= 1'b0;
	endtask
	initial begin
		{core_clk, resetn, psel, penable, pwrite, paddr, pwdata} = 0;
		{run, mode, nblk, fails, num_checks} = 0;
		repeat (16) @(posedge core_clk);
		resetn <= 1'b1;
		t_noresp();
		t_rca();
		t_busy();
		t_err();
		t_single();
		t_open();
		t_predef();
		final_report();
	end
endmodule
`default_nettype wire
